// ===== core/gpm_pkg.sv
`default_nettype none
package gpm_pkg;
    // Bank numbers carried by the bank select value
    localparam logic [3:0] BANK_FG = 4'h5;
    localparam logic [3:0] BANK_H = 4'h8;
    // Register offsets inside a bank
    localparam logic [7:0] OFF_DIRECTION_F = 8'h10;
    localparam logic [7:0] OFF_PINS_LATCH_F = 8'h11;
    localparam logic [7:0] OFF_DIRECTION_G = 8'h12;
    localparam logic [7:0] OFF_PINS_LATCH_G = 8'h13;
    localparam logic [7:0] OFF_CONVERTER_CONTROL_ONE = 8'h15;
    localparam logic [7:0] OFF_DIRECTION_H = 8'h10;
    localparam logic [7:0] OFF_PINS_LATCH_H = 8'h11;
    // Values after reset
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [3:0] RST_PIN_CONFIG = 4'h0;
    localparam logic [2:0] RST_CONV_UPPER = 3'h0;
    localparam logic [15:0] RST_ANALOG_SELECT = 16'hFFFF;
    // Field positions in converter_control_one
    localparam int PIN_CONFIG_FIELD_LSB = 0;
    localparam int PIN_CONFIG_FIELD_MSB = 3;
    localparam int CONV_UPPER_LSB = 5;
    // Pin configuration codes at or above this make every shared pin digital
    localparam logic [3:0] PIN_CONFIG_ALL_DIGITAL = 4'hE;
    // Bit positions of shared port G functions
    localparam int G_CAPTURE_BIT = 4;
    localparam int G_PULSE_BIT = 5;
    localparam int G_RECEIVE_BIT = 6;
    localparam int G_TRANSMIT_BIT = 7;
endpackage
`default_nettype wire

// ===== core/gpm_ports.sv
`default_nettype none
// Summary of operation
// (RQ1) Direction bit one makes a pin input; zero drives it from its latch.
// (RQ2) Reading a port data register returns pin levels, not the latch.
// (RQ3) Writing a port data register loads its latch regardless of direction.
// (RQ4) Ports G and H are eight bits wide, one direction and latch bit per pin.
// (RQ5) Port F bits 0 to 7 may be converter inputs 4 to 11.
// (RQ6) Port G bits 0 to 3 share converter inputs 3 down to 0.
// (RQ7) Port G bit 3 is positive reference input, bit 2 negative reference.
// (RQ8) Port G bit 4 is capture three, bit 5 pulse three, 6 and 7 serial.
// (RQ9) Port G bit 6 carries serial receive or data, bit 7 transmit or clock.
// (RQ10) After reset port G bits 3 to 0 are analog inputs.
// (RQ11) Port H bits 4 to 7 may be converter inputs 12 to 15.
// (RQ12) Port H bits 3 to 0 are plain digital I/O only.
// (RQ13) After reset port H bits 7 to 4 are analog inputs.
// (RQ14) Software selects bank 5 before port F, G and converter registers.
// (RQ15) After reset all port F pins are analog inputs.
// (RQ16) Writes land at the cycle end; reads sample pins at cycle start.
// (RQ17) Read-modify-write reads pins, modifies, writes the latch.
// (RQ18) Config field picks analog pins; analog pins neither drive nor sample.
module gpm_ports
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Banked register access from the processor
    input wire logic [3:0] bank_select,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // Port F pins
    input wire logic [7:0] pin_f_in,
    output logic [7:0] pin_f_out,
    output logic [7:0] pin_f_oe,
    // Port G pins
    input wire logic [7:0] pin_g_in,
    output logic [7:0] pin_g_out,
    output logic [7:0] pin_g_oe,
    // Port H pins
    input wire logic [7:0] pin_h_in,
    output logic [7:0] pin_h_out,
    output logic [7:0] pin_h_oe,
    // Shared peripherals on port G
    input wire logic pulse_out_three_en,
    input wire logic pulse_out_three,
    input wire logic serial_two_transmit_en,
    input wire logic serial_two_transmit,
    input wire logic serial_two_receive_en,
    input wire logic serial_two_receive_out,
    output logic capture_in_three,
    output logic serial_two_receive,
    output logic serial_two_clock_in,
    // Converter side
    output logic [15:0] analog_select,
    output logic ref_external,
    output logic [2:0] converter_upper
);

    typedef struct packed {
        logic [7:0] dir_f;
        logic [7:0] dir_g;
        logic [7:0] dir_h;
        logic [7:0] lat_f;
        logic [7:0] lat_g;
        logic [7:0] lat_h;
        logic [3:0] pin_config;
        logic [2:0] conv_upper;
        logic [7:0] meta_f;
        logic [7:0] meta_g;
        logic [7:0] meta_h;
        logic [7:0] sync_f;
        logic [7:0] sync_g;
        logic [7:0] sync_h;
        logic [7:0] out_f;
        logic [7:0] out_g;
        logic [7:0] out_h;
        logic [7:0] oe_f;
        logic [7:0] oe_g;
        logic [7:0] oe_h;
        logic [7:0] rd_data;
        logic [15:0] an_sel;
        logic ref_ext;
    } gpm_state_t;

    gpm_state_t state_q;
    gpm_state_t state_d;
    logic [15:0] an_mask;
    logic [7:0] an_f;
    logic [7:0] an_g;
    logic [7:0] an_h;
    logic sel_fg;
    logic sel_h;

    // Channel k is analog while k + code stays below 16; top codes all digital
    function automatic logic [15:0] gpm_analog_mask(input logic [3:0] code);
        logic [15:0] m;
        m = 16'h0000;
        for (int k = 0; k < 16; k++)
        begin
            m[k] = (code < gpm_pkg::PIN_CONFIG_ALL_DIGITAL) &&
                   ((5'(k) + {1'b0, code}) < 5'h10);
        end
        return m;
    endfunction

    // Pin is released when it is an input or handed to the converter
    function automatic logic [7:0] gpm_release(input logic [7:0] dir,
                                              input logic [7:0] an);
        return dir | an;
    endfunction

    // Map converter channels onto port bits
    always_comb
    begin
        an_mask = gpm_analog_mask(state_q.pin_config); // RQ18
        an_f = an_mask[11:4]; // RQ5
        an_g = {4'h0, an_mask[0], an_mask[1], an_mask[2], an_mask[3]}; // RQ6
        an_h = {an_mask[15:12], 4'h0}; // RQ11 RQ12
        sel_fg = (bank_select == gpm_pkg::BANK_FG); // RQ14
        sel_h = (bank_select == gpm_pkg::BANK_H);
    end

    // Whole next state: pin sampling, register writes, pin drive, reads
    always_comb
    begin
        state_d = state_q;
        // Two stages before anything looks at a pin
        state_d.meta_f = pin_f_in;
        state_d.meta_g = pin_g_in;
        state_d.meta_h = pin_h_in;
        state_d.sync_f = state_q.meta_f;
        state_d.sync_g = state_q.meta_g;
        state_d.sync_h = state_q.meta_h;
        // Writes land at the end of the access cycle
        if (reg_wr_en && sel_fg)
        begin
            unique case (reg_addr)
                gpm_pkg::OFF_DIRECTION_F: state_d.dir_f = reg_wr_data;
                gpm_pkg::OFF_PINS_LATCH_F: state_d.lat_f = reg_wr_data; // RQ3
                gpm_pkg::OFF_DIRECTION_G: state_d.dir_g = reg_wr_data;
                gpm_pkg::OFF_PINS_LATCH_G: state_d.lat_g = reg_wr_data; // RQ3
                gpm_pkg::OFF_CONVERTER_CONTROL_ONE:
                begin
                    state_d.pin_config = reg_wr_data[
                        gpm_pkg::PIN_CONFIG_FIELD_MSB:
                        gpm_pkg::PIN_CONFIG_FIELD_LSB]; // RQ18
                    state_d.conv_upper =
                        reg_wr_data[gpm_pkg::CONV_UPPER_LSB +: 3];
                end
                default: ;
            endcase
        end
        else if (reg_wr_en && sel_h)
        begin
            unique case (reg_addr)
                gpm_pkg::OFF_DIRECTION_H: state_d.dir_h = reg_wr_data;
                gpm_pkg::OFF_PINS_LATCH_H: state_d.lat_h = reg_wr_data; // RQ3
                default: ;
            endcase
        end
        // Drive from latches; analog pins stay released
        state_d.oe_f = gpm_release(state_q.dir_f, an_f); // RQ1 RQ15
        state_d.oe_g = gpm_release(state_q.dir_g, an_g); // RQ1 RQ10
        state_d.oe_h = gpm_release(state_q.dir_h, an_h); // RQ1 RQ4 RQ13
        state_d.out_f = state_q.lat_f;
        state_d.out_g = state_q.lat_g;
        state_d.out_h = state_q.lat_h;
        // Enabled peripherals take their pin over the latch
        if (pulse_out_three_en)
        begin
            state_d.out_g[gpm_pkg::G_PULSE_BIT] = pulse_out_three; // RQ8
            state_d.oe_g[gpm_pkg::G_PULSE_BIT] = 1'b0;
        end
        if (serial_two_receive_en)
        begin
            state_d.out_g[gpm_pkg::G_RECEIVE_BIT] = serial_two_receive_out; // RQ9
            state_d.oe_g[gpm_pkg::G_RECEIVE_BIT] = 1'b0;
        end
        if (serial_two_transmit_en)
        begin
            state_d.out_g[gpm_pkg::G_TRANSMIT_BIT] = serial_two_transmit; // RQ9
            state_d.oe_g[gpm_pkg::G_TRANSMIT_BIT] = 1'b0;
        end
        // Converter selection; reference pins follow the odd codes below 14
        state_d.an_sel = an_mask; // RQ5 RQ6 RQ11
        state_d.ref_ext = state_q.pin_config[0] && an_mask[0] && an_mask[1]; // RQ7
        // Reads return sampled pins so read-modify-write rewrites pin levels
        if (reg_rd_en)
        begin
            state_d.rd_data = 8'h00;
            if (sel_fg)
            begin
                unique case (reg_addr)
                    gpm_pkg::OFF_DIRECTION_F: state_d.rd_data = state_q.dir_f;
                    gpm_pkg::OFF_PINS_LATCH_F:
                        state_d.rd_data = state_q.sync_f & ~an_f; // RQ2 RQ16 RQ17
                    gpm_pkg::OFF_DIRECTION_G: state_d.rd_data = state_q.dir_g;
                    gpm_pkg::OFF_PINS_LATCH_G:
                        state_d.rd_data = state_q.sync_g & ~an_g; // RQ2 RQ16 RQ17
                    gpm_pkg::OFF_CONVERTER_CONTROL_ONE:
                        state_d.rd_data = {state_q.conv_upper, 1'b0,
                                           state_q.pin_config};
                    default: state_d.rd_data = 8'h00;
                endcase
            end
            else if (sel_h)
            begin
                unique case (reg_addr)
                    gpm_pkg::OFF_DIRECTION_H: state_d.rd_data = state_q.dir_h;
                    gpm_pkg::OFF_PINS_LATCH_H:
                        state_d.rd_data = state_q.sync_h & ~an_h; // RQ2 RQ16
                    default: state_d.rd_data = 8'h00;
                endcase
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= '0;
            state_q.dir_f <= gpm_pkg::RST_DIRECTION;
            state_q.dir_g <= gpm_pkg::RST_DIRECTION;
            state_q.dir_h <= gpm_pkg::RST_DIRECTION;
            state_q.lat_f <= gpm_pkg::RST_LATCH;
            state_q.lat_g <= gpm_pkg::RST_LATCH;
            state_q.lat_h <= gpm_pkg::RST_LATCH;
            state_q.pin_config <= gpm_pkg::RST_PIN_CONFIG; // RQ10 RQ13 RQ15
            state_q.conv_upper <= gpm_pkg::RST_CONV_UPPER;
            state_q.oe_f <= gpm_pkg::RST_DIRECTION;
            state_q.oe_g <= gpm_pkg::RST_DIRECTION;
            state_q.oe_h <= gpm_pkg::RST_DIRECTION;
            state_q.an_sel <= gpm_pkg::RST_ANALOG_SELECT;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign reg_rd_data = state_q.rd_data;
    assign pin_f_out = state_q.out_f;
    assign pin_g_out = state_q.out_g;
    assign pin_h_out = state_q.out_h;
    assign pin_f_oe = state_q.oe_f;
    assign pin_g_oe = state_q.oe_g;
    assign pin_h_oe = state_q.oe_h;
    assign capture_in_three = state_q.sync_g[gpm_pkg::G_CAPTURE_BIT]; // RQ8
    assign serial_two_receive = state_q.sync_g[gpm_pkg::G_RECEIVE_BIT]; // RQ9
    assign serial_two_clock_in = state_q.sync_g[gpm_pkg::G_TRANSMIT_BIT];
    assign analog_select = state_q.an_sel;
    assign ref_external = state_q.ref_ext;
    assign converter_upper = state_q.conv_upper;

    // Looks only at the release edge, so unreset flops at start are skipped
    a_reset_release: assert property (@(posedge ref_clk) // RQ10
        $past(reset) && !reset |->
        (pin_f_oe == 8'hFF) && (pin_g_oe == 8'hFF) &&
        (pin_h_oe == 8'hFF) && (analog_select == 16'hFFFF))
        else $error("pins not released after reset");

    a_latch_write_f: assert property (@(posedge ref_clk) disable iff (reset)
        reg_wr_en && sel_fg && reg_addr == gpm_pkg::OFF_PINS_LATCH_F
        |=> ##1 pin_f_out == $past(reg_wr_data, 2)) // RQ3
        else $error("port f latch write not seen on pins");

    a_dir_drive_h: assert property (@(posedge ref_clk) disable iff (reset)
        !$past(reset) |-> pin_h_oe[3:0] == $past(state_q.dir_h[3:0])) // RQ1
        else $error("port h low pins do not follow direction");

    a_analog_no_drive: assert property (@(posedge ref_clk)
        disable iff (reset)
        !$past(reset) |-> ((~pin_g_oe[3:0] & $past(an_g[3:0])) == 4'h0)) // RQ18
        else $error("analog pin driven");

    a_read_pins_f: assert property (@(posedge ref_clk) disable iff (reset)
        reg_rd_en && sel_fg && reg_addr == gpm_pkg::OFF_PINS_LATCH_F
        |=> reg_rd_data == ($past(pin_f_in, 3) & ~$past(an_f))) // RQ2
        else $error("port f read not from pins");

    a_pulse_takes_pin: assert property (@(posedge ref_clk)
        disable iff (reset)
        pulse_out_three_en |=> !pin_g_oe[5] &&
        pin_g_out[5] == $past(pulse_out_three)) // RQ8
        else $error("pulse output not on port g bit 5");

    a_capture_path: assert property (@(posedge ref_clk) disable iff (reset)
        !$past(reset, 2) |-> capture_in_three == $past(pin_g_in[4], 2)) // RQ8
        else $error("capture input not two stages behind pin");

    a_config_digital: assert property (@(posedge ref_clk)
        disable iff (reset)
        reg_wr_en && sel_fg && reg_addr == gpm_pkg::OFF_CONVERTER_CONTROL_ONE
        && reg_wr_data[3:0] == 4'hE |=> ##1 analog_select == 16'h0000) // RQ18
        else $error("digital configuration not applied");

endmodule
`default_nettype wire

// ===== verif/gpm_pin_model.sv
`default_nettype none
module gpm_pin_model
(
    // Device drive, ports H G F packed high to low
    input wire logic [23:0] dev_out,
    input wire logic [23:0] dev_oe,
    // Levels set by the outside circuit on released pins
    input wire logic [23:0] ext_drive,
    // Resolved pin levels
    output logic [23:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Output enable is active low; released pins follow the outside circuit
    assign pin_level = (dev_oe & ext_drive) | (~dev_oe & dev_out);
endmodule
`default_nettype wire

// ===== verif/gpm_ports_tb.sv
`default_nettype none
module gpm_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [3:0] bank_select = 4'h0;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
    logic [23:0] dev_out, dev_oe, lvl, ext = 24'h000000;
    logic [2:0] p_en = 3'h0, p_val = 3'h0, c_up;
    logic cap, rx, ck, ref_ext, rd_seen = 1'b0;
    logic [15:0] an_sel;
    logic [7:0] exp_q[$];
    int failures = 0, checks_done = 0, cycles = 0;
    logic [7:0] d, l, e, ctl;
    logic [7:0] ds[3];
    logic [15:0] m;
    // Bank, direction and latch offsets of ports F, G, H
    logic [3:0] bk[3] = '{gpm_pkg::BANK_FG, gpm_pkg::BANK_FG, gpm_pkg::BANK_H};
    logic [7:0] od[3] = '{8'h10, 8'h12, 8'h10};
    logic [7:0] ol[3] = '{8'h11, 8'h13, 8'h11};

    gpm_ports uut (.ref_clk(ref_clk), .reset(reset),
        .bank_select(bank_select), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .pin_f_in(lvl[7:0]), .pin_f_out(dev_out[7:0]), .pin_f_oe(dev_oe[7:0]),
        .pin_g_in(lvl[15:8]), .pin_g_out(dev_out[15:8]),
        .pin_g_oe(dev_oe[15:8]), .pin_h_in(lvl[23:16]),
        .pin_h_out(dev_out[23:16]), .pin_h_oe(dev_oe[23:16]),
        .pulse_out_three_en(p_en[0]), .pulse_out_three(p_val[0]),
        .serial_two_receive_en(p_en[1]), .serial_two_receive_out(p_val[1]),
        .serial_two_transmit_en(p_en[2]), .serial_two_transmit(p_val[2]),
        .capture_in_three(cap), .serial_two_receive(rx),
        .serial_two_clock_in(ck), .analog_select(an_sel),
        .ref_external(ref_ext), .converter_upper(c_up));
    gpm_pin_model pins (.dev_out(dev_out), .dev_oe(dev_oe),
        .ext_drive(ext), .pin_level(lvl));

    // Free running clock
    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [3:0] b, input logic [7:0] a, dv);
        bank_select <= b;
        reg_addr <= a;
        reg_wr_data <= dv;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        // Idle edge so back to back calls never retoggle the strobe at once
        @(posedge ref_clk);
    endtask

    // Expected answer is queued; the monitor pops it when data appears
    task automatic rd(input logic [3:0] b, input logic [7:0] a, want);
        exp_q.push_back(want);
        bank_select <= b;
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Analog channel mask for a pin configuration code
    function automatic logic [15:0] amask(input logic [3:0] c);
        for (int k = 0; k < 16; k++)
            amask[k] = (c < gpm_pkg::PIN_CONFIG_ALL_DIGITAL) && (k + c < 16);
    endfunction

    // Read data is settled half a cycle after the answering edge
    always @(posedge ref_clk)
        rd_seen <= reg_rd_en;
    always @(negedge ref_clk)
        if (rd_seen)
            check({8'h00, reg_rd_data}, {8'h00, exp_q.pop_front()});

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        void'($urandom(32'h4473));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        // Look half a cycle after the release edge, once outputs settle
        @(negedge ref_clk);
        // Every converter channel analog and every pin released after reset
        check(dev_oe[15:0], 16'hFFFF);
        check({8'h00, dev_oe[23:16]}, 16'h00FF);
        check(dev_out[15:0], 16'h0000);
        check(an_sel, 16'hFFFF);
        check({15'h0000, ref_ext}, 16'h0000);
        @(posedge ref_clk);
        ext <= 24'hA5C3F0;
        repeat (4) @(posedge ref_clk);
        rd(gpm_pkg::BANK_FG, gpm_pkg::OFF_DIRECTION_F, 8'hFF);
        rd(gpm_pkg::BANK_FG, gpm_pkg::OFF_PINS_LATCH_F, 8'h00);
        rd(gpm_pkg::BANK_H, gpm_pkg::OFF_PINS_LATCH_H,
            ext[23:16] & 8'h0F);
        rd(gpm_pkg::BANK_FG, gpm_pkg::OFF_CONVERTER_CONTROL_ONE, 8'h00);
        $display("reset test done");
        // Every configuration code, decode checked on all ports
        for (int c = 0; c < 16; c++)
        begin
            ctl = {3'($urandom), 1'b0, 4'(c)};
            m = amask(4'(c));
            wr(gpm_pkg::BANK_FG, gpm_pkg::OFF_CONVERTER_CONTROL_ONE, ctl);
            repeat (3) @(posedge ref_clk);
            check(an_sel, m);
            check({15'h0000, ref_ext}, {15'h0000, ctl[0] & m[0] & m[1]});
            check({13'h0000, c_up}, {13'h0000, ctl[7:5]});
            rd(gpm_pkg::BANK_FG, gpm_pkg::OFF_CONVERTER_CONTROL_ONE, ctl);
            rd(bk[0], ol[0], ext[7:0] & ~m[11:4]);
            rd(bk[1], ol[1], ext[15:8] & ~{4'h0, m[0], m[1], m[2], m[3]});
            rd(bk[2], ol[2], ext[23:16] & ~{m[15:12], 4'h0});
        end
        $display("pin configuration test done");
        // Per port: latch loaded while input, then mixed directions
        for (int p = 0; p < 3; p++)
        begin
            d = 8'($urandom);
            ds[p] = d;
            l = 8'($urandom);
            e = 8'($urandom);
            wr(bk[p], od[p], 8'hFF);
            wr(bk[p], ol[p], l);
            wr(bk[p], od[p], d);
            repeat (2) @(posedge ref_clk);
            check({8'h00, dev_oe[p*8 +: 8]}, {8'h00, d});
            check({8'h00, dev_out[p*8 +: 8] & ~d}, {8'h00, l & ~d});
            ext[p*8 +: 8] <= e;
            repeat (4) @(posedge ref_clk);
            rd(bk[p], ol[p], (d & e) | (~d & l));
            rd(bk[p], od[p], d);
        end
        $display("direction and latch test done");
        // Wrong bank and unmapped offsets are refused
        wr(4'h3, gpm_pkg::OFF_DIRECTION_F, 8'h00);
        // Refused write leaves the direction set in the port loop
        rd(gpm_pkg::BANK_FG, gpm_pkg::OFF_DIRECTION_F, ds[0]);
        rd(4'h3, gpm_pkg::OFF_DIRECTION_F, 8'h00);
        rd(gpm_pkg::BANK_H, 8'h13, 8'h00);
        $display("bank test done");
        // Shared peripherals on the upper port G pins
        p_en <= 3'h7;
        p_val <= 3'($urandom);
        e = 8'($urandom);
        ext[15:8] <= e;
        wr(gpm_pkg::BANK_FG, gpm_pkg::OFF_DIRECTION_G, 8'hFF);
        repeat (2) @(posedge ref_clk);
        check({13'h0000, dev_out[15:13]}, {13'h0000, p_val[2], p_val[1],
            p_val[0]});
        check({13'h0000, dev_oe[15:13]}, 16'h0000);
        p_en <= 3'h0;
        repeat (5) @(posedge ref_clk);
        check({13'h0000, ck, rx, cap}, {13'h0000, e[7], e[6], e[4]});
        $display("peripheral test done");
        repeat (4) @(posedge ref_clk);
        end_sim();
    end
endmodule
`default_nettype wire
